// file: hw/periph_irq_pkg.sv
package periph_irq_pkg;
   // Register offsets, byte addresses on the register port.
   localparam logic [7:0] OFFS_FLAGS_ONE = 8'h0C;
   localparam logic [7:0] OFFS_FLAGS_TWO = 8'h0D;
   localparam logic [7:0] OFFS_ENABLES_ONE = 8'h8C;
   localparam logic [7:0] OFFS_ENABLES_TWO = 8'h8D;
   localparam logic [7:0] OFFS_IRQ_STATUS = 8'hF0;
   localparam logic [7:0] OFFS_IRQ_CLEAR = 8'hF1;
   localparam logic [7:0] OFFS_IRQ_ENABLE = 8'hF2;
   // Field positions in the first flag and enable registers.
   localparam int BIT_PARALLEL = 7;
   localparam int BIT_CONVERTER = 6;
   localparam int BIT_RECEIVE = 5;
   localparam int BIT_TRANSMIT = 4;
   localparam int BIT_SERIAL = 3;
   localparam int BIT_CAPTURE_ONE = 2;
   localparam int BIT_TIMER_TWO = 1;
   localparam int BIT_TIMER_ONE = 0;
   // Field position in the second flag and enable registers.
   localparam int BIT_CAPTURE_TWO = 0;
   // Reset values.
   localparam logic [7:0] RESET_FLAGS = 8'h00;
   localparam logic [7:0] RESET_ENABLES = 8'h00;
   localparam logic [8:0] RESET_STATUS = 9'h000;
   // Capture unit modes.
   typedef enum logic [2:0] {
      CCP_CAPTURE = 3'b001,
      CCP_COMPARE = 3'b010,
      CCP_PWM = 3'b100
   } ccp_mode_t;
endpackage

// file: hw/sticky_flag.sv
`timescale 1ns/1ns
// One software-cleared event flag; a set in the clear cycle wins.
module sticky_flag (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Event and clear.
   input wire logic set_pulse,
   input wire logic clr_pulse,
   input wire logic wr_pulse,
   input wire logic wr_value,
   // Flag.
   output logic flag
);
   // The set term is first so an event never gets lost to a clear.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (set_pulse) begin
         flag <= 1'b1;
      end else if (clr_pulse) begin
         flag <= 1'b0;
      end else if (wr_pulse) begin
         flag <= wr_value;
      end
   end
endmodule

// file: hw/peripheral_interrupt_flags.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
// Operation
// - Flags set on their event regardless of any enable bit.
// - Converter-done flag sets on conversion end, held until software clears.
// - Serial-port flag sets on transfer completion, held until cleared.
// - Capture-one flag sets on capture in capture mode; ignored in PWM mode.
// - Capture-one flag sets on compare match in compare mode.
// - Timer-two period flag sets on period match, held until cleared.
// - Timer-one overflow flag sets on rollover, held until cleared.
// - Parallel-port flag sets on each completed external access, if present.
// - Receive flag is read-only, follows buffer full, clears on data read.
// - Transmit flag is read-only, follows buffer empty, clears on data write.
// - Smallest variant reads bits 7, 5 and 4 as zero.
// - Second flag register reads bits 7 to 1 as zero; bit 0 capture-two.
// - Second enable register holds one capture-two enable bit.
// - All flags except receive and transmit reset to zero.
// - First enable register has one enable bit per source.
module peripheral_interrupt_flags
   import periph_irq_pkg::*;
#(
   parameter bit HAS_PARALLEL = 1'b1,
   parameter bit HAS_USART = 1'b1
) (
   // Clock and reset.
   input wire logic CLK,
   input wire logic RST,
   // Register port.
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Peripheral events, one-cycle pulses, and the two capture unit modes.
   input wire logic CONVERTER_DONE,
   input wire logic SERIAL_DONE,
   input wire logic CAPTURE_ONE_EVENT,
   input wire logic COMPARE_ONE_MATCH,
   input wire periph_irq_pkg::ccp_mode_t CAPTURE_ONE_MODE,
   input wire logic CAPTURE_TWO_EVENT,
   input wire logic COMPARE_TWO_MATCH,
   input wire periph_irq_pkg::ccp_mode_t CAPTURE_TWO_MODE,
   input wire logic TIMER_TWO_MATCH,
   input wire logic TIMER_ONE_ROLLOVER,
   input wire logic PARALLEL_ACCESS,
   // Serial buffer levels and the data register accesses that clear them.
   input wire logic RECEIVE_FULL,
   input wire logic TRANSMIT_EMPTY,
   output logic RECEIVE_DATA_READ,
   output logic TRANSMIT_DATA_WRITE,
   input wire logic RX_DATA_READ_REQ,
   input wire logic TX_DATA_WRITE_REQ,
   // Interrupt requests.
   output logic PERIPH_IRQ,
   output logic EVENT_IRQ
);
   import periph_irq_pkg::*;

   typedef struct packed {
      logic [7:0] enables_one;
      logic [7:0] enables_two;
      logic [8:0] status;
      logic [8:0] status_en;
      logic [7:0] rdata;
      logic rx_read;
      logic tx_write;
      logic irq;
      logic event_irq;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic [7:0] set_one;
   logic [7:0] flags_one;
   logic [7:0] view_one;
   logic [7:0] view_two;
   logic flag_two;
   logic set_two;
   logic wr_one;
   logic wr_two;
   logic [8:0] event_vec;

   // Event decode; the mode gates capture and compare events.
   always_comb begin
      set_one = 8'h00;
      set_one[BIT_CONVERTER] = CONVERTER_DONE;
      set_one[BIT_SERIAL] = SERIAL_DONE;
      set_one[BIT_CAPTURE_ONE] = (CAPTURE_ONE_MODE == CCP_CAPTURE && CAPTURE_ONE_EVENT)
         || (CAPTURE_ONE_MODE == CCP_COMPARE && COMPARE_ONE_MATCH);
      set_one[BIT_TIMER_TWO] = TIMER_TWO_MATCH;
      set_one[BIT_TIMER_ONE] = TIMER_ONE_ROLLOVER;
      set_one[BIT_PARALLEL] = HAS_PARALLEL && PARALLEL_ACCESS;
      set_two = (CAPTURE_TWO_MODE == CCP_CAPTURE && CAPTURE_TWO_EVENT)
         || (CAPTURE_TWO_MODE == CCP_COMPARE && COMPARE_TWO_MATCH);
   end

   assign wr_one = WR && (ADDR == OFFS_FLAGS_ONE);
   assign wr_two = WR && (ADDR == OFFS_FLAGS_TWO);

   // Writable event flags; receive and transmit bits never get a cell here.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         if (gi == BIT_RECEIVE || gi == BIT_TRANSMIT) begin : g_none
            assign flags_one[gi] = 1'b0;
         end else begin : g_cell
            sticky_flag u_flag (
               .clk(CLK),
               .rst(RST),
               .set_pulse(set_one[gi]),
               .clr_pulse(1'b0),
               .wr_pulse(wr_one),
               .wr_value(WDATA[gi]),
               .flag(flags_one[gi])
            );
         end
      end
   endgenerate

   sticky_flag u_flag_two (
      .clk(CLK),
      .rst(RST),
      .set_pulse(set_two),
      .clr_pulse(1'b0),
      .wr_pulse(wr_two),
      .wr_value(WDATA[BIT_CAPTURE_TWO]),
      .flag(flag_two)
   );

   // Read views; absent sources read zero so a variant build stays honest.
   always_comb begin
      view_one = flags_one;
      view_one[BIT_RECEIVE] = HAS_USART && RECEIVE_FULL;
      view_one[BIT_TRANSMIT] = HAS_USART && TRANSMIT_EMPTY;
      if (!HAS_PARALLEL) begin
         view_one[BIT_PARALLEL] = 1'b0;
      end
      view_two = 8'h00;
      view_two[BIT_CAPTURE_TWO] = flag_two;
   end

   assign event_vec = {set_two, set_one};

   // Next state: enables, sticky event status, read data and requests.
   always_comb begin
      state_next = state_reg;
      state_next.rx_read = RX_DATA_READ_REQ;
      state_next.tx_write = TX_DATA_WRITE_REQ;
      state_next.rdata = 8'h00;
      if (WR && ADDR == OFFS_ENABLES_ONE) begin
         state_next.enables_one = WDATA;
      end else if (WR && ADDR == OFFS_ENABLES_TWO) begin
         state_next.enables_two = {7'h00, WDATA[BIT_CAPTURE_TWO]};
      end else if (WR && ADDR == OFFS_IRQ_ENABLE) begin
         state_next.status_en = {WDATA[0], WDATA};
      end
      if (WR && ADDR == OFFS_IRQ_CLEAR) begin
         state_next.status = state_reg.status & ~{WDATA[0], WDATA};
      end
      // Set wins over the clear in the same cycle.
      state_next.status = state_next.status | event_vec;
      if (RD) begin
         if (ADDR == OFFS_FLAGS_ONE) begin
            state_next.rdata = view_one;
         end else if (ADDR == OFFS_FLAGS_TWO) begin
            state_next.rdata = view_two;
         end else if (ADDR == OFFS_ENABLES_ONE) begin
            state_next.rdata = state_reg.enables_one;
         end else if (ADDR == OFFS_ENABLES_TWO) begin
            state_next.rdata = state_reg.enables_two;
         end else if (ADDR == OFFS_IRQ_STATUS) begin
            state_next.rdata = state_reg.status[7:0];
         end else if (ADDR == OFFS_IRQ_ENABLE) begin
            state_next.rdata = state_reg.status_en[7:0];
         end
      end
      // Registered request; one cycle late against the flags, glitch free.
      state_next.irq = |(view_one & state_reg.enables_one)
         || (view_two[BIT_CAPTURE_TWO] && state_reg.enables_two[BIT_CAPTURE_TWO]);
      state_next.event_irq = |(state_reg.status & state_reg.status_en);
   end

   // Single register stage for all state.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg.enables_one <= RESET_ENABLES;
         state_reg.enables_two <= RESET_ENABLES;
         state_reg.status <= RESET_STATUS;
         state_reg.status_en <= RESET_STATUS;
         state_reg.rdata <= RESET_FLAGS;
         state_reg.rx_read <= 1'b0;
         state_reg.tx_write <= 1'b0;
         state_reg.irq <= 1'b0;
         state_reg.event_irq <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign RDATA = state_reg.rdata;
   assign RECEIVE_DATA_READ = state_reg.rx_read;
   assign TRANSMIT_DATA_WRITE = state_reg.tx_write;
   assign PERIPH_IRQ = state_reg.irq;
   assign EVENT_IRQ = state_reg.event_irq;
endmodule

// file: dv/periph_irq_properties.sv
`timescale 1ns/1ns
// Watches the register port and the serial clear strobes.
module periph_irq_properties (
   // Clock and reset.
   input wire logic CLK,
   input wire logic RST,
   // Register port.
   input wire logic [7:0] ADDR,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   // Sources and serial strobes.
   input wire logic CONVERTER_DONE,
   input wire logic RECEIVE_FULL,
   input wire logic TRANSMIT_EMPTY,
   input wire logic RX_DATA_READ_REQ,
   input wire logic TX_DATA_WRITE_REQ,
   input wire logic RECEIVE_DATA_READ,
   input wire logic TRANSMIT_DATA_WRITE
);
   // One clock domain, so one default clock and reset serve every check.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   a_conv_flag_set: assert property (CONVERTER_DONE ##1 !WR [*2] ##1 (RD && ADDR == 8'h0C)
      |=> RDATA[6]) else $error("converter flag not seen");
   a_rx_clear_pulse: assert property (RX_DATA_READ_REQ |=> RECEIVE_DATA_READ)
      else $error("receive clear pulse missing");
   a_tx_clear_pulse: assert property (TX_DATA_WRITE_REQ |=> TRANSMIT_DATA_WRITE)
      else $error("transmit clear pulse missing");
   a_rx_only_req: assert property (RECEIVE_DATA_READ |-> $past(RX_DATA_READ_REQ))
      else $error("receive clear without request");
   a_tx_only_req: assert property (TRANSMIT_DATA_WRITE |-> $past(TX_DATA_WRITE_REQ))
      else $error("transmit clear without request");
   a_rx_level_read: assert property (RD && ADDR == 8'h0C |=> RDATA[5] == $past(RECEIVE_FULL))
      else $error("receive flag wrong");
   a_tx_level_read: assert property (RD && ADDR == 8'h0C |=> RDATA[4] == $past(TRANSMIT_EMPTY))
      else $error("transmit flag wrong");
   a_two_upper_zero: assert property (RD && ADDR == 8'h0D |=> RDATA[7:1] == 7'h00)
      else $error("second flag upper bits set");
endmodule
bind peripheral_interrupt_flags periph_irq_properties periph_irq_properties_inst (.CLK, .RST,
   .ADDR, .WR, .RD, .RDATA, .CONVERTER_DONE, .RECEIVE_FULL, .TRANSMIT_EMPTY,
   .RX_DATA_READ_REQ, .TX_DATA_WRITE_REQ, .RECEIVE_DATA_READ, .TRANSMIT_DATA_WRITE);

// file: dv/usart_stub.sv
`timescale 1ns/1ns
// Serial buffer levels as the block sees them from the serial port.
module usart_stub (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Arrival and the block's clear strobes.
   input wire logic arrive,
   input wire logic rx_taken,
   input wire logic tx_loaded,
   // Buffer levels.
   output logic rx_full,
   output logic tx_empty
);
   logic [3:0] shift_cnt;
   // The transmit buffer stays full while a byte shifts out, so the low level is observable.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_full <= 1'b0;
         tx_empty <= 1'b1;
         shift_cnt <= 4'h0;
      end else begin
         rx_full <= arrive | (rx_full & ~rx_taken);
         if (tx_loaded) begin
            tx_empty <= 1'b0;
            shift_cnt <= 4'hF;
         end else if (shift_cnt != 4'h0) begin
            shift_cnt <= shift_cnt - 4'h1;
            tx_empty <= (shift_cnt == 4'h1);
         end
      end
   end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
   $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module tb;
   import periph_irq_pkg::*;
   logic CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, arrive = 1'b0, rx_req = 1'b0;
   logic tx_req = 1'b0, rx_full, tx_empty, rx_done, tx_done, irq, eirq;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, r;
   logic [9:0] ev = 10'h000;
   ccp_mode_t m1 = CCP_CAPTURE, m2 = CCP_CAPTURE;
   int n_fail = 0, checks = 0, src[6] = '{0, 1, 2, 3, 6, 7}, cc[4] = '{2, 4, 8, 9};
   always #4 CLK = ~CLK;
   // Event vector: bit 4 is compare one, bits 8 and 9 are capture and compare two.
   peripheral_interrupt_flags peripheral_interrupt_flags_inst (.CLK, .RST, .ADDR, .WDATA, .WR,
      .RD, .RDATA, .CONVERTER_DONE(ev[6]), .SERIAL_DONE(ev[3]), .CAPTURE_ONE_EVENT(ev[2]),
      .COMPARE_ONE_MATCH(ev[4]), .CAPTURE_ONE_MODE(m1), .CAPTURE_TWO_EVENT(ev[8]),
      .COMPARE_TWO_MATCH(ev[9]), .CAPTURE_TWO_MODE(m2), .TIMER_TWO_MATCH(ev[1]),
      .TIMER_ONE_ROLLOVER(ev[0]), .PARALLEL_ACCESS(ev[7]), .RECEIVE_FULL(rx_full),
      .TRANSMIT_EMPTY(tx_empty), .RECEIVE_DATA_READ(rx_done), .TRANSMIT_DATA_WRITE(tx_done),
      .RX_DATA_READ_REQ(rx_req), .TX_DATA_WRITE_REQ(tx_req), .PERIPH_IRQ(irq), .EVENT_IRQ(eirq));
   usart_stub usart_stub_inst (.clk(CLK), .rst(RST), .arrive, .rx_taken(rx_done),
      .tx_loaded(tx_done), .rx_full, .tx_empty);
   // Expected first flag byte, with the two serial bits taken from the buffer levels.
   function automatic logic [7:0] f1(input logic [7:0] f);
      return {f[7:6], rx_full, tx_empty, f[3:0]};
   endfunction
   // Capture events count only in capture mode, compare matches only in compare mode.
   function automatic logic [7:0] hit(input int m, input int e);
      logic h;
      h = (m == 0 && (e == 2 || e == 8)) || (m == 1 && (e == 4 || e == 9));
      return e > 7 ? {7'h00, h} : f1({5'h00, h, 2'h0});
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
      @(posedge CLK) WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge CLK) {ADDR, RD} <= {a, 1'b1};
      @(posedge CLK) RD <= 1'b0;
      #1 `CHK(RDATA, e)
   endtask
   task automatic pulse(input int b);
      @(posedge CLK) ev[b] <= 1'b1;
      @(posedge CLK) ev[b] <= 1'b0;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // The tests need well under two thousand cycles.
   initial begin
      #100000;
      n_fail++;
      complete_run();
   end
   initial begin
      void'($urandom(32'h623B));
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      rd(OFFS_FLAGS_ONE, 8'h10);
      rd(OFFS_FLAGS_TWO, 8'h00);
      rd(OFFS_ENABLES_ONE, 8'h00);
      $display("reset test done");
      foreach (src[i]) begin
         r = $urandom() & 8'hCF;
         wr(OFFS_FLAGS_ONE, 8'h00);
         wr(OFFS_ENABLES_ONE, r);
         pulse(src[i]);
         @(posedge CLK) #1 `CHK(irq, r[src[i]])
         rd(OFFS_FLAGS_ONE, f1(8'h01 << src[i]));
         wr(OFFS_FLAGS_ONE, 8'h00);
      end
      $display("event test done");
      for (int m = 0; m < 3; m++) begin
         @(posedge CLK) {m1, m2} <= {ccp_mode_t'(3'h1 << m), ccp_mode_t'(3'h1 << m)};
         foreach (cc[i]) begin
            pulse(cc[i]);
            rd(cc[i] > 7 ? OFFS_FLAGS_TWO : OFFS_FLAGS_ONE, hit(m, cc[i]));
            wr(OFFS_FLAGS_ONE, 8'h00);
            wr(OFFS_FLAGS_TWO, 8'h00);
         end
      end
      $display("mode test done");
      @(posedge CLK) {m1, m2} <= {CCP_CAPTURE, CCP_CAPTURE};
      wr(OFFS_ENABLES_ONE, 8'h00);
      wr(OFFS_ENABLES_TWO, 8'hFF);
      rd(OFFS_ENABLES_TWO, 8'h01);
      pulse(8);
      @(posedge CLK) #1 `CHK(irq, 1'b1)
      wr(OFFS_FLAGS_TWO, 8'h00);
      @(posedge CLK) #1 `CHK(irq, 1'b0)
      wr(OFFS_IRQ_ENABLE, 8'h40);
      wr(OFFS_IRQ_CLEAR, 8'hFF);
      pulse(6);
      @(posedge CLK) #1 `CHK(eirq, 1'b1)
      rd(OFFS_IRQ_STATUS, 8'h40);
      wr(OFFS_IRQ_CLEAR, 8'hFF);
      @(posedge CLK) #1 `CHK(eirq, 1'b0)
      $display("interrupt test done");
      @(posedge CLK) arrive <= 1'b1;
      @(posedge CLK) arrive <= 1'b0;
      wr(OFFS_FLAGS_ONE, 8'h00);
      rd(OFFS_FLAGS_ONE, 8'h30);
      @(posedge CLK) {rx_req, tx_req} <= 2'b11;
      @(posedge CLK) {rx_req, tx_req} <= 2'b00;
      repeat (2) @(posedge CLK);
      rd(OFFS_FLAGS_ONE, 8'h00);
      repeat (20) @(posedge CLK);
      rd(OFFS_FLAGS_ONE, 8'h10);
      rd(8'h40, 8'h00);
      $display("serial test done");
      complete_run();
   end
endmodule
